/* File: pkg/eccp_pkg.sv */
// Constants shared by the capture/compare/PWM unit.
// Assumes an 8-bit register port and a 40 MHz oscillator clock.
package eccp_pkg;
    // Register offsets
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_VALUE_LOW = 4'h1;
    localparam logic [3:0] OFS_VALUE_HIGH = 4'h2;
    localparam logic [3:0] OFS_DEAD_BAND = 4'h3;
    localparam logic [3:0] OFS_FLAG_REG2 = 4'h4;
    localparam logic [3:0] OFS_ENABLE_REG2 = 4'h5;
    localparam logic [3:0] OFS_PERIOD = 4'h6;
    localparam logic [3:0] OFS_TB_CONTROL = 4'h7;
    localparam logic [3:0] OFS_TB_COUNT = 4'h8;
    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DEAD_BAND_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hFF;
    localparam logic [2:0] TB_CONTROL_RESET = 3'h0;
    // Field positions
    localparam int DIR_BIT = 7;
    localparam int CFG_LSB = 6;
    localparam int DUTY_LSB = 4;
    localparam int TB_ON_BIT = 2;
    localparam int FLAG_BIT = 0;
    // Output configurations
    localparam logic [1:0] CFG_SINGLE = 2'h0;
    localparam logic [1:0] CFG_FORWARD = 2'h1;
    localparam logic [1:0] CFG_HALF = 2'h2;
    localparam logic [1:0] CFG_REVERSE = 2'h3;
    // Mode codes
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_4TH = 4'h6;
    localparam logic [3:0] MODE_CAP_16TH = 4'h7;
    localparam logic [3:0] MODE_SET = 4'h8;
    localparam logic [3:0] MODE_CLEAR = 4'h9;
    localparam logic [3:0] MODE_NONE = 4'hA;
    localparam logic [3:0] MODE_SPECIAL = 4'hB;
    // Oscillator periods per instruction cycle
    localparam int TOSC_PER_TCY = 4;
    localparam int ENH_DELAY_CLKS = TOSC_PER_TCY;
endpackage

/* File: src/eccp_unit.sv */
// Enhanced capture/compare/PWM unit with its own PWM time base.
// Assumes ref_clk is the oscillator clock, inputs are synchronous,
// and pin direction is handled by the port logic outside.
module eccp_unit (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Capture/compare timer and converter
    input wire logic [15:0] timer_value,
    input wire logic adc_enabled,
    output logic timer_clear,
    output logic adc_start,
    // Capture pin
    input wire logic capture_in,
    // Bridge outputs
    output logic out_a,
    output logic out_a_oe,
    output logic out_b,
    output logic out_b_oe,
    output logic out_c,
    output logic out_c_oe,
    output logic out_d,
    output logic out_d_oe,
    // Gated event request
    output logic unit_event_request
);

    // Clocks per time base step for a prescale code
    function automatic logic [4:0] presc_clocks(input logic [1:0] code);
        if (code[1]) begin
            presc_clocks = 5'h10;
        end else if (code[0]) begin
            presc_clocks = 5'h04;
        end else begin
            presc_clocks = 5'h01;
        end
    endfunction

    function automatic logic is_pwm(input logic [3:0] m);
        is_pwm = (m[3:2] == 2'h3);
    endfunction

    function automatic logic is_capture(input logic [3:0] m);
        is_capture = (m[3:2] == 2'h1);
    endfunction

    function automatic logic is_compare(input logic [3:0] m);
        is_compare = (m == eccp_pkg::MODE_TOGGLE) || (m[3:2] == 2'h2);
    endfunction

    // One step of a dead-band counter, saturating at the limit
    function automatic logic [9:0] dead_step(input logic [9:0] cnt,
                                             input logic target,
                                             input logic [9:0] lim);
        if (!target) begin
            dead_step = 10'h000;
        end else if (cnt == lim) begin
            dead_step = cnt;
        end else begin
            dead_step = 10'(cnt + 10'h001);
        end
    endfunction

    logic [7:0] unit_control;
    logic [15:0] capture_compare_value;
    logic [7:0] dead_band_count;
    logic [7:0] pwm_period_value;
    logic [2:0] tb_control;
    logic unit_event_flag;
    logic unit_event_enable;
    logic [3:0] mode;
    logic [1:0] time_base_prescale;
    logic tb_on;
    logic [4:0] presc_cnt;
    logic [9:0] fine;
    logic fine_tick;
    logic last_step;
    logic boundary;
    logic [9:0] next_fine;
    logic [9:0] next_duty;
    logic [9:0] duty_act;
    logic [1:0] cfg_act;
    logic [1:0] pol_act;
    logic [7:0] db_act;
    logic [9:0] dly_clk;
    logic pwm_run;
    logic pwm_std;
    logic [eccp_pkg::ENH_DELAY_CLKS-1:0] dly_sr;
    logic pwm_dly;
    logic [9:0] cnt_a;
    logic [9:0] cnt_b;
    logic act_a;
    logic act_b;
    logic early;
    logic la, lb, lc, ld;
    logic cap_prev;
    logic cap_rise;
    logic cap_fall;
    logic [3:0] cap_cnt;
    logic cap_event;
    logic match;
    logic match_prev;
    logic cmp_hit;
    logic special;
    logic cmp_out;
    logic ctrl_wr;

    assign mode = unit_control[3:0];
    assign time_base_prescale = tb_control[1:0];
    assign tb_on = tb_control[eccp_pkg::TB_ON_BIT];
    assign ctrl_wr = wr && (addr == eccp_pkg::OFS_CONTROL);

    // Time base: ten-bit count, one step per prescaled oscillator group
    assign fine_tick = tb_on && (presc_cnt >= 5'(presc_clocks(time_base_prescale) - 5'h01));
    assign last_step = (fine == {pwm_period_value, 2'h3});
    assign boundary = fine_tick && last_step;
    assign next_fine = fine_tick ? (last_step ? 10'h000 : 10'(fine + 10'h001)) : fine;
    assign next_duty = boundary ? {capture_compare_value[7:0],
                                   unit_control[5:4]} : duty_act;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            presc_cnt <= 5'h00;
            fine <= 10'h000;
        end else begin
            presc_cnt <= (!tb_on || fine_tick) ? 5'h00 : 5'(presc_cnt + 5'h01);
            fine <= next_fine;
        end
    end

    // Buffered PWM controls, taken only at the period boundary
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            duty_act <= 10'h000;
            cfg_act <= eccp_pkg::CFG_SINGLE;
            pol_act <= 2'h0;
        end else if (boundary) begin
            duty_act <= next_duty;
            cfg_act <= unit_control[eccp_pkg::CFG_LSB +: 2];
            pol_act <= unit_control[1:0];
        end
    end

    // Dead band reload at either duty end or period end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            db_act <= eccp_pkg::DEAD_BAND_RESET;
        end else if (boundary || (fine_tick && next_fine == duty_act)) begin
            db_act <= dead_band_count;
        end
    end

    // PWM starts only once the time base has wrapped
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pwm_run <= 1'b0;
        end else if (!is_pwm(mode)) begin
            pwm_run <= 1'b0;
        end else if (boundary) begin
            pwm_run <= 1'b1;
        end
    end

    // Standard waveform; a duty beyond the period never clears it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pwm_std <= 1'b0;
        end else begin
            pwm_std <= (is_pwm(mode) && (pwm_run || boundary)) && (next_fine < next_duty);
        end
    end

    // One instruction cycle of lag for the enhanced configurations
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dly_sr <= '0;
        end else begin
            dly_sr <= {dly_sr[eccp_pkg::ENH_DELAY_CLKS-2:0], pwm_std};
        end
    end
    assign pwm_dly = dly_sr[eccp_pkg::ENH_DELAY_CLKS-1];

    // Dead-band counters delay each rising edge by count*4 clocks
    assign dly_clk = {db_act, 2'h0};
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_a <= 10'h000;
            cnt_b <= 10'h000;
        end else begin
            cnt_a <= dead_step(cnt_a, pwm_dly, dly_clk);
            cnt_b <= dead_step(cnt_b, !pwm_dly, dly_clk);
        end
    end
    // Never reaching the limit keeps the output inactive
    assign act_a = pwm_dly && (cnt_a == dly_clk);
    assign act_b = !pwm_dly && (cnt_b == dly_clk);

    // Direction change inside the last time base step of a period
    assign early = pwm_run && cfg_act[0] && unit_control[eccp_pkg::CFG_LSB] &&
                   (unit_control[eccp_pkg::DIR_BIT] != cfg_act[1]) &&
                   tb_on && last_step;

    // Logical output levels per configuration
    always_comb begin
        la = 1'b0;
        lb = 1'b0;
        lc = 1'b0;
        ld = 1'b0;
        if (early) begin
            la = !unit_control[eccp_pkg::DIR_BIT];
            lc = unit_control[eccp_pkg::DIR_BIT];
        end else begin
            unique case (cfg_act)
                eccp_pkg::CFG_SINGLE: begin
                    la = pwm_std;
                end
                eccp_pkg::CFG_HALF: begin
                    la = act_a;
                    lb = act_b;
                end
                eccp_pkg::CFG_FORWARD: begin
                    la = 1'b1;
                    ld = pwm_dly;
                end
                eccp_pkg::CFG_REVERSE: begin
                    lc = 1'b1;
                    lb = pwm_dly;
                end
            endcase
        end
    end

    // Pin drive: polarity applied, unused pins released to the port
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_a <= 1'b0;
            out_b <= 1'b0;
            out_c <= 1'b0;
            out_d <= 1'b0;
            out_a_oe <= 1'b0;
            out_b_oe <= 1'b0;
            out_c_oe <= 1'b0;
            out_d_oe <= 1'b0;
        end else begin
            out_a <= pwm_run ? (la ^ pol_act[1]) : cmp_out;
            out_c <= pwm_run && (lc ^ pol_act[1]);
            out_b <= pwm_run && (lb ^ pol_act[0]);
            out_d <= pwm_run && (ld ^ pol_act[0]);
            out_a_oe <= pwm_run || is_compare(mode);
            out_b_oe <= pwm_run && (cfg_act != eccp_pkg::CFG_SINGLE);
            out_c_oe <= pwm_run && cfg_act[0];
            out_d_oe <= pwm_run && cfg_act[0];
        end
    end

    // Capture edge detection and prescaling; pin edges are the only source
    assign cap_rise = capture_in && !cap_prev;
    assign cap_fall = !capture_in && cap_prev;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cap_prev <= 1'b0;
            cap_cnt <= 4'h0;
        end else begin
            cap_prev <= capture_in;
            if (!is_capture(mode) || ctrl_wr) begin
                cap_cnt <= 4'h0;
            end else if (cap_rise) begin
                cap_cnt <= 4'(cap_cnt + 4'h1);
            end
        end
    end
    always_comb begin
        unique case (mode)
            eccp_pkg::MODE_CAP_FALL: cap_event = cap_fall;
            eccp_pkg::MODE_CAP_RISE: cap_event = cap_rise;
            eccp_pkg::MODE_CAP_4TH: cap_event = cap_rise && (cap_cnt[1:0] == 2'h3);
            eccp_pkg::MODE_CAP_16TH: cap_event = cap_rise && (cap_cnt == 4'hF);
            default: cap_event = 1'b0;
        endcase
    end

    // Compare match, one event per match entry
    assign match = is_compare(mode) && (timer_value == capture_compare_value);
    assign cmp_hit = match && !match_prev;
    assign special = cmp_hit && (mode == eccp_pkg::MODE_SPECIAL);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            match_prev <= 1'b0;
            cmp_out <= 1'b0;
        end else begin
            match_prev <= match;
            if (mode == eccp_pkg::MODE_OFF) begin
                cmp_out <= 1'b0;
            end else if (cmp_hit) begin
                unique case (mode)
                    eccp_pkg::MODE_TOGGLE: cmp_out <= !cmp_out;
                    eccp_pkg::MODE_SET: cmp_out <= 1'b1;
                    eccp_pkg::MODE_CLEAR: cmp_out <= 1'b0;
                    default: cmp_out <= cmp_out;
                endcase
            end
        end
    end

    // Special trigger: timer clear strobe carries no overflow flag
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            timer_clear <= 1'b0;
            adc_start <= 1'b0;
        end else begin
            timer_clear <= special;
            adc_start <= special && adc_enabled;
        end
    end

    // Control and time base registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            unit_control <= eccp_pkg::CONTROL_RESET;
            dead_band_count <= eccp_pkg::DEAD_BAND_RESET;
            pwm_period_value <= eccp_pkg::PERIOD_RESET;
            tb_control <= eccp_pkg::TB_CONTROL_RESET;
            unit_event_enable <= 1'b0;
        end else if (wr) begin
            unique case (addr)
                eccp_pkg::OFS_CONTROL: unit_control <= wdata;
                eccp_pkg::OFS_DEAD_BAND: dead_band_count <= wdata;
                eccp_pkg::OFS_PERIOD: pwm_period_value <= wdata;
                eccp_pkg::OFS_TB_CONTROL: tb_control <= wdata[2:0];
                eccp_pkg::OFS_ENABLE_REG2: unit_event_enable <= wdata[eccp_pkg::FLAG_BIT];
                default: ;
            endcase
        end
    end

    // Value register: capture beats duty latch beats software
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            capture_compare_value <= 16'h0000;
        end else if (cap_event) begin
            capture_compare_value <= timer_value;
        end else begin
            if (wr && addr == eccp_pkg::OFS_VALUE_LOW) begin
                capture_compare_value[7:0] <= wdata;
            end
            if (is_pwm(mode) && boundary) begin
                capture_compare_value[15:8] <= capture_compare_value[7:0];
            end else if (wr && addr == eccp_pkg::OFS_VALUE_HIGH && !is_pwm(mode)) begin
                capture_compare_value[15:8] <= wdata;
            end
        end
    end

    // Event flag: hardware set wins over a software clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            unit_event_flag <= 1'b0;
            unit_event_request <= 1'b0;
        end else begin
            if (cap_event || cmp_hit) begin
                unit_event_flag <= 1'b1;
            end else if (wr && addr == eccp_pkg::OFS_FLAG_REG2) begin
                unit_event_flag <= wdata[eccp_pkg::FLAG_BIT];
            end
            unit_event_request <= unit_event_flag && unit_event_enable;
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            unique case (addr)
                eccp_pkg::OFS_CONTROL: rdata <= unit_control;
                eccp_pkg::OFS_VALUE_LOW: rdata <= capture_compare_value[7:0];
                eccp_pkg::OFS_VALUE_HIGH: rdata <= capture_compare_value[15:8];
                eccp_pkg::OFS_DEAD_BAND: rdata <= dead_band_count;
                eccp_pkg::OFS_FLAG_REG2: rdata <= {7'h00, unit_event_flag};
                eccp_pkg::OFS_ENABLE_REG2: rdata <= {7'h00, unit_event_enable};
                eccp_pkg::OFS_PERIOD: rdata <= pwm_period_value;
                eccp_pkg::OFS_TB_CONTROL: rdata <= {5'h00, tb_control};
                eccp_pkg::OFS_TB_COUNT: rdata <= fine[9:2];
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // Checks on the logic above
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_capture_seen;
        cap_event ##1 1'b1;
    endsequence

    a_capture_stores: assert property (
        cap_event |=> capture_compare_value == $past(timer_value))
        else $error("capture value not stored");

    a_flag_on_event: assert property (s_capture_seen |-> unit_event_flag)
        else $error("event flag not set after capture");

    a_request_gate: assert property (
        unit_event_request |-> $past(unit_event_flag) && $past(unit_event_enable))
        else $error("request without enabled flag");

    a_adc_start: assert property (
        special && adc_enabled |=> adc_start && timer_clear)
        else $error("special trigger did not start conversion");

    a_lag_four: assert property (
        pwm_dly == $past(pwm_std, 4))
        else $error("enhanced lag is not four clocks");

    a_period_load: assert property (
        !boundary |=> $stable(cfg_act) && $stable(duty_act))
        else $error("controls changed off the boundary");

    a_dead_band: assert property (
        act_a && db_act != 8'h00 |-> $past(pwm_dly, 1) && $past(pwm_dly, 2) &&
        $past(pwm_dly, 3) && $past(pwm_dly, 4))
        else $error("output A active before dead band expired");

    a_forward_hold: assert property (
        pwm_run && cfg_act == eccp_pkg::CFG_FORWARD && !early
        |=> out_a == !$past(pol_act[1]) && out_b == $past(pol_act[0]))
        else $error("forward bridge levels wrong");

    a_early_turn: assert property (
        early |=> out_b == $past(pol_act[0]) && out_d == $past(pol_act[0]) &&
        out_a == (!$past(unit_control[eccp_pkg::DIR_BIT]) ^ $past(pol_act[1])) &&
        out_c == ($past(unit_control[eccp_pkg::DIR_BIT]) ^ $past(pol_act[1])))
        else $error("modulated outputs active during turn");

    a_release_pins: assert property (
        !is_pwm(mode) |-> ##2 !out_b_oe && !out_c_oe && !out_d_oe)
        else $error("bridge pins driven outside PWM");

endmodule // eccp_unit

/* File: verification/bridge_driver_model.sv */
// Model of the external power switch drivers on the four bridge pins.
// Assumes pull-downs hold each switch off while its pin floats.
module bridge_driver_model (
    // Clock and window control
    input wire logic ref_clk,
    input wire logic clr,
    // Pin drive from the unit
    input wire logic [3:0] drv,
    input wire logic [3:0] drv_oe,
    // Gate-high cycles per leg, d down to a
    output logic [3:0][7:0] on_cnt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] gate;
    // Released pins read low through the pull-downs
    assign gate = drv & drv_oe;
    // Count gate-high cycles since the last clear
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (clr) begin
                on_cnt[i] <= 8'h00;
            end else begin
                on_cnt[i] <= on_cnt[i] + {7'h00, gate[i]};
            end
        end
    end
endmodule // bridge_driver_model

/* File: verification/enhanced_capture_compare_pwm_tb.sv */
// Self-checking bench for the capture/compare/PWM unit.
// Assumes register offsets 0..8 and one 40 MHz clock.
module enhanced_capture_compare_pwm_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [15:0] timer_value = 16'h0000;
    logic adc_enabled = 1'b0;
    logic capture_in = 1'b0;
    logic clr = 1'b0;
    logic timer_clear;
    logic adc_start;
    logic unit_event_request;
    logic [3:0] drv;
    logic [3:0] drv_oe;
    logic [3:0][7:0] on_cnt;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n_clr = 0;
    int n_adc = 0;
    logic [3:0] cmp_mode [7] = '{4'h8, 4'h9, 4'h2, 4'h2, 4'hA, 4'hB, 4'hB};
    logic cmp_out [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    // Control, dead band, then expected high cycles of pins d c b a
    logic [47:0] pwm_tab [8] = '{48'h1C_00_00_00_00_09, 48'h1E_00_00_00_00_07,
        48'h9C_01_00_00_03_05, 48'h9D_01_00_00_0D_05, 48'h9C_03_00_00_00_00,
        48'h5C_00_09_00_00_10, 48'hDC_00_00_10_09_00, 48'hDF_00_10_00_07_10};

    eccp_unit dut (
        .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .timer_value(timer_value), .adc_enabled(adc_enabled),
        .timer_clear(timer_clear), .adc_start(adc_start), .capture_in(capture_in),
        .out_a(drv[0]), .out_a_oe(drv_oe[0]), .out_b(drv[1]), .out_b_oe(drv_oe[1]),
        .out_c(drv[2]), .out_c_oe(drv_oe[2]), .out_d(drv[3]), .out_d_oe(drv_oe[3]),
        .unit_event_request(unit_event_request)
    );

    bridge_driver_model partner (
        .ref_clk(ref_clk), .clr(clr), .drv(drv), .drv_oe(drv_oe), .on_cnt(on_cnt)
    );

    // Clock generator
    always #12.5 ref_clk = ~ref_clk;

    // Pulse tally and hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (timer_clear === 1'b1) n_clr++;
        if (adc_start === 1'b1) n_adc++;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 chk(32'(rdata & m), 32'(e));
    endtask

    task automatic pulse();
        @(posedge ref_clk);
        capture_in <= 1'b1;
        tick(2);
        capture_in <= 1'b0;
        tick(2);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        int need;
        tick(20);
        rst <= 1'b0;
        rd_chk(4'h0, 8'hFF, eccp_pkg::CONTROL_RESET);
        rd_chk(4'h3, 8'hFF, eccp_pkg::DEAD_BAND_RESET);
        rd_chk(4'h6, 8'hFF, eccp_pkg::PERIOD_RESET);
        rd_chk(4'h9, 8'hFF, 8'h00);
        wr_reg(4'h5, 8'h01);
        // Capture on each edge kind; pins b to d kept inputs
        for (int m = 4; m < 8; m++) begin
            need = (m == 6) ? 4 : (m == 7) ? 16 : 1;
            timer_value <= {4'(m), 12'h5C3};
            wr_reg(4'h0, 8'(m));
            wr_reg(4'h4, 8'h00);
            for (int k = 1; k <= need; k++) begin
                if (k == need) rd_chk(4'h4, 8'h01, 8'h00);
                pulse();
            end
            tick(3);
            chk(32'(unit_event_request), 32'h1);
            rd_chk(4'h1, 8'hFF, 8'hC3);
            rd_chk(4'h2, 8'hFF, {4'(m), 4'h5});
            chk(32'(drv_oe[3:1]), 32'h0);
        end
        // Compare matches for every compare code
        wr_reg(4'h0, 8'h00);
        wr_reg(4'h1, 8'h00);
        wr_reg(4'h2, 8'h01);
        adc_enabled <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            wr_reg(4'h0, {4'h0, cmp_mode[i]});
            wr_reg(4'h4, 8'h00);
            if (i == 6) adc_enabled <= 1'b0;
            @(posedge ref_clk);
            timer_value <= 16'h0100;
            @(posedge ref_clk);
            timer_value <= 16'h0000;
            tick(3);
            chk(32'(drv[0]), 32'(cmp_out[i]));
            rd_chk(4'h4, 8'h01, 8'h01);
        end
        chk(n_clr, 2);
        chk(n_adc, 1);
        // PWM: period 16 clocks, duty 9 clocks
        wr_reg(4'h6, 8'h03);
        wr_reg(4'h1, 8'h02);
        wr_reg(4'h7, 8'h04);
        for (int i = 0; i < 8; i++) begin
            wr_reg(4'h3, pwm_tab[i][39:32]);
            wr_reg(4'h0, pwm_tab[i][47:40]);
            tick(40);
            @(posedge ref_clk);
            clr <= 1'b1;
            @(posedge ref_clk);
            clr <= 1'b0;
            tick(16);
            #1 chk(on_cnt, pwm_tab[i][31:0]);
        end
        // Slower time base steps stretch period and duty alike
        wr_reg(4'h0, 8'h1C);
        for (int p = 1; p < 3; p++) begin
            wr_reg(4'h7, 8'(4 + p));
            tick(600);
            @(posedge ref_clk);
            clr <= 1'b1;
            @(posedge ref_clk);
            clr <= 1'b0;
            tick((p == 1) ? 64 : 256);
            #1 chk(on_cnt, (p == 1) ? 32'h24 : 32'h90);
        end
        tally_and_finish();
    end
endmodule // enhanced_capture_compare_pwm_tb
